// ### inc/lmon_defs.svh
// Behaviour
// - compare sample magnitude against phase threshold
// - comparator false above threshold, else true
// - phase threshold is 32-bit unsigned word
// - lock after 2^X true divider periods
// - lock holds until unlock, reset or disable
// - lock exponent 5 bits, kept 0 to 20; not clamped, above 20 locks only after 2^21 true ticks
// - unlock after 2^(Y+1) false periods
// - unlock clears lock, restarts qualification
// - unlock exponent 3 bits, 0 to 7
// - frequency detector uses successive sample difference
// - frequency detector has own interval fields
// - independent enabled watchdog per reference
// - loss sets live and sticky flags
// - each live loss flag routable to pin
// - rising edge resets; full count flags loss
// - terminal count from own 16-bit word
// - watchdog advances every two system clocks
`ifndef LMON_DEFS_SVH
`define LMON_DEFS_SVH

`define LMON_SAMPLE_W     32
`define LMON_MAG_W        33
`define LMON_THR_W        32
`define LMON_LOCK_EXP_W   5
`define LMON_LOCK_EXP_MAX 20
`define LMON_UNLK_EXP_W   3
`define LMON_LOCK_CNT_W   21
`define LMON_UNLK_CNT_W   9
`define LMON_WD_W         16
`define LMON_WD_MIN       3
`define LMON_WD_DIV       2
`define LMON_NUM_REF      2
`define LMON_NUM_PINS     4
`define LMON_PIN_SEL_W    2

`endif

// ### inc/lmon_pkg.sv
`include "lmon_defs.svh"

package lmon_pkg;

    // lock qualifier state
    typedef enum logic [0:0] {
        LMON_ACQUIRE = 1'b0,
        LMON_LOCKED  = 1'b1
    } lmon_lock_st_t;

    // settings of one lock detector
    typedef struct packed {
        logic                          enable;
        logic [`LMON_THR_W-1:0]        threshold;
        logic [`LMON_LOCK_EXP_W-1:0]   lock_exp;
        logic [`LMON_UNLK_EXP_W-1:0]   unlock_exp;
    } lmon_lock_cfg_t;

    // settings of one reference watchdog
    typedef struct packed {
        logic                          enable;
        logic [`LMON_WD_W-1:0]         term_count;
        logic                          pin_en;
        logic [`LMON_PIN_SEL_W-1:0]    pin_sel;
    } lmon_lor_cfg_t;

endpackage

// ### rtl/lmon_lock_qual.sv
`timescale 1ns/1ps
`include "lmon_defs.svh"

module lmon_lock_qual (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       sys_rst_i,
    // settings
    input  wire lmon_pkg::lmon_lock_cfg_t   cfg_i,
    // magnitude stream and divider tick
    input  wire logic [`LMON_MAG_W-1:0]     mag_i,
    input  wire logic                       mag_vld_i,
    input  wire logic                       div_tick_i,
    // indication
    output logic                            locked_o
);

    lmon_pkg::lmon_lock_st_t       st_ff;
    lmon_pkg::lmon_lock_st_t       nxt_st;
    logic                          cmp_ff;
    logic [`LMON_LOCK_CNT_W-1:0]   run_ff;
    logic [`LMON_LOCK_CNT_W-1:0]   nxt_run;
    logic [`LMON_UNLK_CNT_W-1:0]   bad_ff;
    logic [`LMON_UNLK_CNT_W-1:0]   nxt_bad;
    wire  logic                    cmp_now;
    wire  logic [`LMON_LOCK_CNT_W-1:0] lock_goal;
    wire  logic [`LMON_UNLK_CNT_W-1:0] unlk_goal;
    wire  logic [`LMON_LOCK_CNT_W-1:0] run_inc;
    wire  logic [`LMON_UNLK_CNT_W-1:0] bad_inc;

    // true when the sample lies within the threshold
    assign cmp_now = (mag_i <= {1'b0, cfg_i.threshold});
    // an exponent above the legal range gives a goal of zero: locks only after 2^21 true ticks, when the count wraps
    assign lock_goal = `LMON_LOCK_CNT_W'(1) << cfg_i.lock_exp;
    assign unlk_goal = `LMON_UNLK_CNT_W'(2) << cfg_i.unlock_exp;
    assign run_inc = run_ff + `LMON_LOCK_CNT_W'(1);
    assign bad_inc = bad_ff + `LMON_UNLK_CNT_W'(1);

    // count whole divider periods with the comparator held true or false
    always_comb begin
        nxt_st  = st_ff;
        nxt_run = run_ff;
        nxt_bad = bad_ff;
        if (div_tick_i) begin
            unique case (st_ff)
                lmon_pkg::LMON_ACQUIRE: begin
                    nxt_bad = '0;
                    if (!cmp_ff) begin
                        nxt_run = '0;
                    end else if (run_inc == lock_goal) begin
                        nxt_st  = lmon_pkg::LMON_LOCKED;
                        nxt_run = '0;
                    end else begin
                        nxt_run = run_inc;
                    end
                end
                lmon_pkg::LMON_LOCKED: begin
                    nxt_run = '0;
                    if (cmp_ff) begin
                        nxt_bad = '0;
                    end else if (bad_inc == unlk_goal) begin
                        nxt_st  = lmon_pkg::LMON_ACQUIRE;
                        nxt_bad = '0;
                    end else begin
                        nxt_bad = bad_inc;
                    end
                end
            endcase
        end
    end

    // a disabled detector sits cleared, like a reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !cfg_i.enable) begin
            st_ff    <= lmon_pkg::LMON_ACQUIRE;
            cmp_ff   <= 1'b0;
            run_ff   <= '0;
            bad_ff   <= '0;
            locked_o <= 1'b0;
        end else begin
            if (mag_vld_i) begin
                cmp_ff <= cmp_now;
            end
            st_ff    <= nxt_st;
            run_ff   <= nxt_run;
            bad_ff   <= nxt_bad;
            locked_o <= (nxt_st == lmon_pkg::LMON_LOCKED);
        end
    end

endmodule

// ### rtl/lmon_top.sv
`timescale 1ns/1ps
`include "lmon_defs.svh"

module lmon_top (
    // clock and reset
    input  wire logic                         clk_sys_i,
    input  wire logic                         sys_rst_i,

    // phase detector sample stream
    input  wire logic [`LMON_SAMPLE_W-1:0]    phase_sample_i,
    input  wire logic                         phase_sample_vld_i,

    // loop sample divider period pulse
    input  wire logic                         sample_div_tick_i,

    // lock detector settings
    input  wire lmon_pkg::lmon_lock_cfg_t     phase_cfg_i,
    input  wire lmon_pkg::lmon_lock_cfg_t     freq_cfg_i,

    // reference inputs, synchronous to the clock
    input  wire logic                         first_reference_input_i,
    input  wire logic                         second_reference_input_i,

    // reference watchdog settings
    input  wire lmon_pkg::lmon_lor_cfg_t      first_ref_cfg_i,
    input  wire lmon_pkg::lmon_lor_cfg_t      second_ref_cfg_i,

    // sticky flag clear, one bit per reference
    input  wire logic [`LMON_NUM_REF-1:0]     ref_loss_irq_clr_i,

    // lock indications
    output logic                              phase_lock_o,
    output logic                              freq_lock_o,

    // live loss status, one bit per reference
    output logic [`LMON_NUM_REF-1:0]          reference_absent_flag_o,

    // sticky loss flags, one bit per reference
    output logic [`LMON_NUM_REF-1:0]          ref_loss_irq_o,

    // status pins
    output logic [`LMON_NUM_PINS-1:0]         multipurpose_status_pins_o
);

    // ------------------------------------------------------------
    // sample path
    // ------------------------------------------------------------

    logic signed [`LMON_SAMPLE_W-1:0]   cur_ff;
    logic signed [`LMON_SAMPLE_W-1:0]   prev_ff;
    logic                               cur_vld_ff;
    logic                               have_prev_ff;
    logic [`LMON_MAG_W-1:0]             phase_mag_ff;
    logic                               phase_mag_vld_ff;
    logic [`LMON_MAG_W-1:0]             freq_mag_ff;
    logic                               freq_mag_vld_ff;

    wire  logic signed [`LMON_MAG_W-1:0] cur_ext;
    wire  logic signed [`LMON_MAG_W-1:0] prev_ext;
    wire  logic signed [`LMON_MAG_W-1:0] step_diff;
    wire  logic [`LMON_MAG_W-1:0]        cur_abs;
    wire  logic [`LMON_MAG_W-1:0]        step_abs;

    // sign-extend by one bit so the most negative sample has a magnitude
    assign cur_ext  = {cur_ff[`LMON_SAMPLE_W-1], cur_ff};
    assign prev_ext = {prev_ff[`LMON_SAMPLE_W-1], prev_ff};

    // running difference approximates the frequency error
    assign step_diff = cur_ext - prev_ext;

    // magnitudes of the phase sample and of the step
    assign cur_abs  = cur_ext[`LMON_MAG_W-1] ?
                      `LMON_MAG_W'(-cur_ext) : `LMON_MAG_W'(cur_ext);
    assign step_abs = step_diff[`LMON_MAG_W-1] ?
                      `LMON_MAG_W'(-step_diff) :
                      `LMON_MAG_W'(step_diff);

    // capture each new sample and keep the one before it
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cur_ff     <= '0;
            prev_ff    <= '0;
            cur_vld_ff <= 1'b0;
        end else begin
            cur_vld_ff <= phase_sample_vld_i;
            if (phase_sample_vld_i) begin
                cur_ff  <= phase_sample_i;
                prev_ff <= cur_ff;
            end
        end
    end

    // a step only means something once two samples have been seen
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !freq_cfg_i.enable) begin
            have_prev_ff <= 1'b0;
        end else if (cur_vld_ff) begin
            have_prev_ff <= 1'b1;
        end
    end

    // register magnitudes to keep the subtract and compare apart
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            phase_mag_ff     <= '0;
            phase_mag_vld_ff <= 1'b0;
            freq_mag_ff      <= '0;
            freq_mag_vld_ff  <= 1'b0;
        end else begin
            phase_mag_vld_ff <= cur_vld_ff;
            freq_mag_vld_ff  <= cur_vld_ff && have_prev_ff;
            if (cur_vld_ff) begin
                phase_mag_ff <= cur_abs;
                freq_mag_ff  <= step_abs;
            end
        end
    end

    // ------------------------------------------------------------
    // lock detectors: phase is index 0, frequency index 1
    // ------------------------------------------------------------

    lmon_pkg::lmon_lock_cfg_t  det_cfg [2];
    wire  logic [`LMON_MAG_W-1:0] det_mag [2];
    wire  logic [1:0]             det_vld;
    wire  logic [1:0]             det_lock;

    // each detector keeps its own threshold and interval fields
    assign det_cfg[0] = phase_cfg_i;
    assign det_cfg[1] = freq_cfg_i;
    assign det_mag[0] = phase_mag_ff;
    assign det_mag[1] = freq_mag_ff;
    assign det_vld    = {freq_mag_vld_ff, phase_mag_vld_ff};

    genvar d;
    generate
        for (d = 0; d < 2; d = d + 1) begin : g_det
            lmon_lock_qual u_qual (
                .clk_sys_i  (clk_sys_i),
                .sys_rst_i  (sys_rst_i),
                .cfg_i      (det_cfg[d]),
                .mag_i      (det_mag[d]),
                .mag_vld_i  (det_vld[d]),
                .div_tick_i (sample_div_tick_i),
                .locked_o   (det_lock[d])
            );
        end
    endgenerate

    // lock outputs are not gated by reference status; software does that
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            phase_lock_o <= 1'b0;
            freq_lock_o  <= 1'b0;
        end else begin
            phase_lock_o <= det_lock[0];
            freq_lock_o  <= det_lock[1];
        end
    end

    // ------------------------------------------------------------
    // watchdog time base
    // ------------------------------------------------------------

    logic  wd_phase_ff;
    wire   logic wd_tick;

    // half-rate enable; the counters see every other clock
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_phase_ff <= 1'b0;
        end else begin
            wd_phase_ff <= ~wd_phase_ff;
        end
    end
    assign wd_tick = wd_phase_ff;

    // ------------------------------------------------------------
    // loss-of-reference watchdogs, one per reference
    // ------------------------------------------------------------

    lmon_pkg::lmon_lor_cfg_t      ref_cfg [`LMON_NUM_REF];
    wire  logic [`LMON_NUM_REF-1:0] ref_in;
    logic [`LMON_NUM_REF-1:0]     ref_q_ff;
    logic [`LMON_WD_W-1:0]        wd_cnt_ff [`LMON_NUM_REF];
    logic [`LMON_NUM_REF-1:0]     lost_ff;
    logic [`LMON_NUM_REF-1:0]     sticky_ff;
    wire  logic [`LMON_NUM_REF-1:0] ref_rise;
    wire  logic [`LMON_NUM_REF-1:0] wd_full;
    wire  logic [`LMON_NUM_REF-1:0] lost_set;

    assign ref_cfg[0] = first_ref_cfg_i;
    assign ref_cfg[1] = second_ref_cfg_i;
    assign ref_in     = {second_reference_input_i,
                         first_reference_input_i};

    genvar r;
    generate
        for (r = 0; r < `LMON_NUM_REF; r = r + 1) begin : g_wd
            wire logic [`LMON_WD_W-1:0] cnt_inc;

            // edges come from the synchronous sample of the pin
            assign ref_rise[r] = ref_in[r] & ~ref_q_ff[r];
            assign cnt_inc     = wd_cnt_ff[r] + `LMON_WD_W'(1);
            // a too-slow reference and a missing one look the same
            assign wd_full[r]  = (wd_cnt_ff[r] >= ref_cfg[r].term_count);
            assign lost_set[r] = wd_full[r] && !ref_rise[r];

            // previous pin level for edge detection
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    ref_q_ff[r] <= 1'b0;
                end else begin
                    ref_q_ff[r] <= ref_in[r];
                end
            end

            // counter restarts on every rising edge, holds at full
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i || !ref_cfg[r].enable) begin
                    wd_cnt_ff[r] <= '0;
                end else if (ref_rise[r]) begin
                    wd_cnt_ff[r] <= '0;
                end else if (wd_tick && !wd_full[r]) begin
                    wd_cnt_ff[r] <= cnt_inc;
                end
            end

            // live status follows the watchdog state
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i || !ref_cfg[r].enable) begin
                    lost_ff[r] <= 1'b0;
                end else begin
                    lost_ff[r] <= lost_set[r];
                end
            end

            // sticky flag: a new loss wins over a clear in one cycle
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i || !ref_cfg[r].enable) begin
                    sticky_ff[r] <= 1'b0;
                end else if (lost_set[r]) begin
                    sticky_ff[r] <= 1'b1;
                end else if (ref_loss_irq_clr_i[r]) begin
                    sticky_ff[r] <= 1'b0;
                end
            end
        end
    endgenerate

    assign reference_absent_flag_o = lost_ff;
    assign ref_loss_irq_o          = sticky_ff;

    // ------------------------------------------------------------
    // status pin routing
    // ------------------------------------------------------------

    wire  logic [`LMON_NUM_PINS-1:0] pin_nxt;

    // a pin shows the OR of every loss flag steered onto it
    genvar p;
    generate
        for (p = 0; p < `LMON_NUM_PINS; p = p + 1) begin : g_pin
            wire logic [`LMON_NUM_REF-1:0] hit;
            assign hit[0] = ref_cfg[0].pin_en &&
                            (ref_cfg[0].pin_sel == `LMON_PIN_SEL_W'(p));
            assign hit[1] = ref_cfg[1].pin_en &&
                            (ref_cfg[1].pin_sel == `LMON_PIN_SEL_W'(p));
            assign pin_nxt[p] = |(hit & lost_set);
        end
    endgenerate

    // registered so the pins change on the same edge as live status
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            multipurpose_status_pins_o <= '0;
        end else begin
            multipurpose_status_pins_o <= pin_nxt & {`LMON_NUM_PINS{
                1'b1}};
        end
    end

endmodule

// ### tb/lmon_top_sva.sv
`timescale 1ns/1ps
`include "lmon_defs.svh"
module lmon_top_sva (
    // clock and reset
    input wire logic                      clk_sys_i,
    input wire logic                      sys_rst_i,
    // lock side
    input wire logic [`LMON_SAMPLE_W-1:0] phase_sample_i,
    input wire logic                      phase_sample_vld_i,
    input wire logic                      sample_div_tick_i,
    input wire lmon_pkg::lmon_lock_cfg_t  phase_cfg_i,
    input wire lmon_pkg::lmon_lock_cfg_t  freq_cfg_i,
    input wire logic                      phase_lock_o,
    input wire logic                      freq_lock_o,
    // watchdog side
    input wire logic                      first_reference_input_i,
    input wire logic                      second_reference_input_i,
    input wire lmon_pkg::lmon_lor_cfg_t   first_ref_cfg_i,
    input wire lmon_pkg::lmon_lor_cfg_t   second_ref_cfg_i,
    input wire logic [`LMON_NUM_REF-1:0]  ref_loss_irq_clr_i,
    input wire logic [`LMON_NUM_REF-1:0]  reference_absent_flag_o,
    input wire logic [`LMON_NUM_REF-1:0]  ref_loss_irq_o,
    input wire logic [`LMON_NUM_PINS-1:0] multipurpose_status_pins_o
);
    // pins the live flags may drive under the present routing
    logic [3:0] exp_pins;
    assign exp_pins = ((first_ref_cfg_i.pin_en && reference_absent_flag_o[0])
                       ? (4'h1 << first_ref_cfg_i.pin_sel) : 4'h0)
                    | ((second_ref_cfg_i.pin_en && reference_absent_flag_o[1])
                       ? (4'h1 << second_ref_cfg_i.pin_sel) : 4'h0);

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // a clear whose next cycle shows no live loss
    sequence s_clr_no_loss;
        ref_loss_irq_clr_i[0] ##1 !reference_absent_flag_o[0];
    endsequence

    a_lock_after_tick: assert property (
        $rose(phase_lock_o) |-> $past(sample_div_tick_i, 2))
        else $error("phase lock rose without a tick");
    a_lock_holds: assert property (
        $fell(phase_lock_o) |-> $past(sample_div_tick_i, 2)
        || $past(sys_rst_i) || !$past(phase_cfg_i.enable)
        || !$past(phase_cfg_i.enable, 2))
        else $error("phase lock dropped on its own");
    a_freq_after_tick: assert property (
        $rose(freq_lock_o) |-> $past(sample_div_tick_i, 2))
        else $error("freq lock rose without a tick");
    a_phase_disable: assert property (
        !phase_cfg_i.enable |-> ##2 !phase_lock_o)
        else $error("phase lock kept while disabled");
    a_loss_no_rise: assert property (
        $rose(reference_absent_flag_o[0])
        && first_ref_cfg_i.term_count >= 16'h0003
        |-> !($past(first_reference_input_i)
              && !$past(first_reference_input_i, 2))
        && !($past(first_reference_input_i, 3)
             && !$past(first_reference_input_i, 4)))
        else $error("loss flagged right after an edge");
    a_rise_clears: assert property (
        $rose(first_reference_input_i)
        && first_ref_cfg_i.term_count >= 16'h0003
        |-> ##[1:3] !reference_absent_flag_o[0])
        else $error("edge did not clear loss");
    a_loss_sets_irq: assert property (
        ((reference_absent_flag_o & ~$past(reference_absent_flag_o))
         & ~ref_loss_irq_o) == 2'h0)
        else $error("loss without sticky flag");
    a_sticky_holds: assert property (
        ref_loss_irq_o[0] && !ref_loss_irq_clr_i[0]
        && first_ref_cfg_i.enable |=> ref_loss_irq_o[0])
        else $error("sticky flag lost");
    a_clear_works: assert property (
        s_clr_no_loss |-> !ref_loss_irq_o[0])
        else $error("sticky flag not cleared");
    a_disable_clears: assert property (
        !second_ref_cfg_i.enable
        |=> !reference_absent_flag_o[1] && !ref_loss_irq_o[1])
        else $error("disabled watchdog flags");
    a_pin_follows: assert property (
        $rose(reference_absent_flag_o[0]) && first_ref_cfg_i.pin_en
        && $stable(first_ref_cfg_i)
        |-> multipurpose_status_pins_o[first_ref_cfg_i.pin_sel])
        else $error("routed pin missed loss");
    a_pin_no_stray: assert property (
        $stable(first_ref_cfg_i) && $stable(second_ref_cfg_i)
        |-> ((multipurpose_status_pins_o
              & ~$past(multipurpose_status_pins_o)) & ~exp_pins) == 4'h0)
        else $error("stray pin rise");
endmodule

bind lmon_top lmon_top_sva u_lmon_top_sva (.clk_sys_i, .sys_rst_i,
    .phase_sample_i, .phase_sample_vld_i, .sample_div_tick_i, .phase_cfg_i,
    .freq_cfg_i, .phase_lock_o, .freq_lock_o, .first_reference_input_i,
    .second_reference_input_i, .first_ref_cfg_i, .second_ref_cfg_i,
    .ref_loss_irq_clr_i, .reference_absent_flag_o, .ref_loss_irq_o,
    .multipurpose_status_pins_o);

// ### tb/lmon_ref_src.sv
`timescale 1ns/1ps
module lmon_ref_src (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // control from the bench
    input  wire logic        run_i,
    input  wire logic [15:0] period_i,
    // reference level
    output logic             ref_o
);
    logic [15:0] cnt_ff;
    // one high cycle per period; a stopped reference idles low
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !run_i) begin
            cnt_ff <= 16'h0000;
            ref_o  <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == period_i - 16'h0001) ?
                      16'h0000 : cnt_ff + 16'h0001;
            ref_o  <= (cnt_ff == 16'h0000);
        end
    end
endmodule

// ### tb/lmon_top_tb.sv
`timescale 1ns/1ps
`include "lmon_defs.svh"
module lmon_top_tb;
    logic                     clk_sys_i;
    logic                     sys_rst_i;
    logic [31:0]              smp;
    logic                     smp_vld;
    logic                     tick;
    lmon_pkg::lmon_lock_cfg_t pcfg;
    lmon_pkg::lmon_lock_cfg_t fcfg;
    lmon_pkg::lmon_lor_cfg_t  rcfg0;
    lmon_pkg::lmon_lor_cfg_t  rcfg1;
    logic                     ref0;
    logic                     ref1;
    logic                     run0;
    logic                     run1;
    logic [1:0]               clr;
    logic [1:0]               absent;
    logic [1:0]               irq;
    logic                     plock;
    logic                     flock;
    logic [3:0]               pins;
    int                       error_cnt = 0;
    int                       check_count = 0;
    int                       cyc_cnt = 0;

    lmon_top u_lmon_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .phase_sample_i(smp), .phase_sample_vld_i(smp_vld),
        .sample_div_tick_i(tick), .phase_cfg_i(pcfg), .freq_cfg_i(fcfg),
        .first_reference_input_i(ref0), .second_reference_input_i(ref1),
        .first_ref_cfg_i(rcfg0), .second_ref_cfg_i(rcfg1),
        .ref_loss_irq_clr_i(clr), .phase_lock_o(plock), .freq_lock_o(flock),
        .reference_absent_flag_o(absent), .ref_loss_irq_o(irq),
        .multipurpose_status_pins_o(pins));
    lmon_ref_src u_lmon_ref_src (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .run_i(run0), .period_i(16'h0006), .ref_o(ref0));
    lmon_ref_src u_lmon_ref_src_b (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .run_i(run1), .period_i(16'h0006),
        .ref_o(ref1));

    // 40 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc_cnt++;
        if (cyc_cnt == 8000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude;
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one divider period: a sample, then a tick once it has settled
    task automatic period(input logic [31:0] s, input logic t);
        @(posedge clk_sys_i);
        smp     <= s;
        smp_vld <= 1'b1;
        @(posedge clk_sys_i);
        smp_vld <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        tick <= t;
        @(posedge clk_sys_i);
        tick <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    // phase detector: lock after 4 true ticks, unlock after 2 false
    task automatic phase_seq;
        @(posedge clk_sys_i);
        pcfg <= '{1'b1, 32'h00000005, 5'h02, 3'h0};
        repeat (3) period(32'hfffffffb, 1'b1);       // -5 equals threshold
        period(32'hfffffffb, 1'b0);                  // no tick, no count
        chk_bit(plock, 1'b0);
        period(32'hfffffffb, 1'b1);
        chk_bit(plock, 1'b1);
        period(32'h00000006, 1'b1);
        period(32'hfffffffb, 1'b1);                  // true tick resets the false count
        period(32'h00000006, 1'b1);
        chk_bit(plock, 1'b1);
        period(32'h00000006, 1'b1);
        chk_bit(plock, 1'b0);
        repeat (3) period(32'hfffffffb, 1'b1);
        chk_bit(plock, 1'b0);
        period(32'hfffffffb, 1'b1);
        chk_bit(plock, 1'b1);
        @(posedge clk_sys_i);
        pcfg.enable <= 1'b0;
        period(32'hfffffffb, 1'b0);
        chk_bit(plock, 1'b0);
    endtask

    // frequency detector: lock after 1 tick, unlock after 4 false
    task automatic freq_seq;
        @(posedge clk_sys_i);
        fcfg <= '{1'b1, 32'h00000003, 5'h00, 3'h1};
        period(32'h00000064, 1'b0);                  // primes the difference
        period(32'h00000067, 1'b1);
        chk_bit(flock, 1'b1);
        for (int i = 0; i < 4; i++) begin
            chk_bit(flock, 1'b1);
            period(32'h0000006e + 32'(7 * i), 1'b1);
        end
        chk_bit(flock, 1'b0);
        period(32'h00000080, 1'b1);                  // step of -3
        chk_bit(flock, 1'b1);
    endtask

    // reference watchdogs: loss timing, routing, sticky clear, disable
    task automatic lor_seq;
        int n;
        @(posedge clk_sys_i);
        rcfg0 <= '{1'b1, 16'h0005, 1'b1, 2'h2};
        rcfg1 <= '{1'b1, 16'h0005, 1'b1, 2'h0};
        run0  <= 1'b1;
        run1  <= 1'b1;
        repeat (40) @(negedge clk_sys_i);
        chk_vec({irq, absent}, 4'h0);
        for (n = 0; n < 8 && ref0 !== 1'b1; n++) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        run0 <= 1'b0;
        n = 0;
        while (n < 40 && absent[0] !== 1'b1) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk_bit(n >= 9 && n <= 13, 1'b1);
        chk_vec({absent, irq}, 4'h5);
        chk_vec(pins, 4'h4);
        // lock stays raw during loss, so software must qualify it
        chk_bit(flock, 1'b1);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_sys_i);
            rcfg0.pin_sel <= 2'(s);
            repeat (2) @(negedge clk_sys_i);
            chk_vec(pins, 4'h1 << s);
        end
        @(posedge clk_sys_i);
        clr <= 2'h1;                                 // clear while loss is live
        @(posedge clk_sys_i);
        clr <= 2'h0;
        @(negedge clk_sys_i);
        chk_vec({2'h0, irq}, 4'h1);
        run0 <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk_vec({absent, irq}, 4'h1);
        chk_vec(pins, 4'h0);
        @(posedge clk_sys_i);
        clr <= 2'h1;
        @(posedge clk_sys_i);
        clr <= 2'h0;
        @(negedge clk_sys_i);
        chk_vec({absent, irq}, 4'h0);
        run1 <= 1'b0;
        repeat (16) @(negedge clk_sys_i);
        chk_vec({absent, irq}, 4'ha);
        chk_vec(pins, 4'h1);
        @(posedge clk_sys_i);
        rcfg1.enable <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk_vec({absent, irq}, 4'h0);
        @(posedge clk_sys_i);
        fcfg.enable <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(flock, 1'b0);
    endtask

    // reset, then the scenarios in turn
    initial begin
        sys_rst_i = 1'b1;
        smp = 32'h00000000;
        smp_vld = 1'b0;
        tick = 1'b0;
        pcfg = '0;
        fcfg = '0;
        rcfg0 = '0;
        rcfg1 = '0;
        run0 = 1'b0;
        run1 = 1'b0;
        clr = 2'h0;
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk_vec({plock, flock, absent}, 4'h0);
        chk_vec(pins | {2'h0, irq}, 4'h0);
        phase_seq();
        freq_seq();
        lor_seq();
        conclude();
    end
endmodule
